// ==== logic/oscc_pkg.sv ====
// Package: register map, field layout and timing for oscillator trim logic
package oscc_pkg;
	// Register offsets (byte addresses)
	localparam logic [3:0] OSCC_CTRL_OFS   = 4'h0; // osc_cal_control
	localparam logic [3:0] OSCC_STAT_OFS   = 4'h4; // osc_cal_statistics
	localparam logic [3:0] OSCC_CFG_OFS    = 4'h8; // Applied trim readback, read only
	// osc_cal_control fields
	localparam int OSCC_UT_LSB    = 0;   // user_trim_value [6:0]
	localparam int OSCC_TRIM_W    = 7;
	localparam int OSCC_UPD_BIT   = 8;   // Update strobe, self clears
	localparam int OSCC_USER_TRIM_ENABLE_BIT  = 31;  // user_trim_enable
	localparam int OSCC_CAL_BIT   = 9;   // Start calibration
	// osc_cal_statistics fields
	localparam int OSCC_CT_LSB    = 0;   // computed_trim_value [6:0]
	localparam int OSCC_RES_LSB   = 8;   // Result [9:8]
	localparam int OSCC_BUSY_BIT  = 10;
	// Result codes
	localparam logic [1:0] OSCC_RES_NONE = 2'h0;
	localparam logic [1:0] OSCC_RES_OK   = 2'h1;
	localparam logic [1:0] OSCC_RES_FAIL = 2'h2;
	// Reset values
	localparam logic [6:0] OSCC_TRIM_RST = 7'h40; // Mid scale
	// Nominal oscillator 16 MHz; reference 32.768 kHz -> 488.28 cycles
	localparam int OSCC_OSC_HZ = 16000000;
	localparam int OSCC_REF_HZ = 32768;
	localparam int OSCC_REF_PERIODS = 16;  // Reference periods measured
	localparam int OSCC_TARGET = (OSCC_OSC_HZ / OSCC_REF_HZ) * OSCC_REF_PERIODS;
	// Apply delay in oscillator periods for a glitch free update
	localparam int OSCC_APPLY_CYC = 3;
	localparam int OSCC_REF_TMO = 2048;   // Cycles without ref edge = fail
endpackage : oscc_pkg

// ==== logic/oscc_trim.sv ====
// Oscillator trim and calibration controller, single clock
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
// Notes on behaviour
// [RULE_01] Trim steers oscillator toward 16 MHz nominal
// [RULE_02] Auto calibration counts oscillator against reference
// [RULE_03] Start bit write launches automatic calibration
// [RULE_04] Calibration outcome readable in result field
// [RULE_05] Computed trim exposed and applied on completion
// [RULE_06] Software trims manually without a reference
// [RULE_07] Larger user trim gives lower frequency
// [RULE_08] Software: enable, write trim, then update
// [RULE_09] New trim applied within few periods, glitch free
// [RULE_10] Update bit self clears once trim applied
module oscc_trim
	import oscc_pkg::*;
#(
	parameter int TRIM_W = OSCC_TRIM_W, // Trim code width
	parameter int CNT_W  = 16           // Measurement counter width
) (
	input  wire logic        sys_clk_i,  // Oscillator clock
	input  wire logic        rst_n_i,    // Sync reset, active low
	input  wire logic        ref_clk_i,  // 32.768 kHz reference level
	input  wire logic [3:0]  addr_i,     // Register byte address
	input  wire logic [31:0] wdata_i,    // Write data
	input  wire logic        wr_i,       // Write strobe
	input  wire logic        rd_i,       // Read strobe
	output logic      [31:0] rdata_o,    // Read data, cycle after rd_i
	output logic [TRIM_W-1:0] trim_o     // Trim code to oscillator
);
	// Counter must hold the target count of one measurement window
	if (TRIM_W != OSCC_TRIM_W || CNT_W < 14 || CNT_W > 24) begin : g_bad_par
		$error("oscc_trim: unsupported parameters");
	end

	typedef enum logic [1:0] {
		OSCC_IDLE = 2'b00,
		OSCC_SYNC = 2'b01,
		OSCC_MEAS = 2'b11,
		OSCC_DONE = 2'b10
	} oscc_state_e;

	oscc_state_e         state_reg, state_next;
	logic [2:0]          ref_sync_reg;
	logic                ref_prev_reg;
	logic [TRIM_W-1:0]   ut_reg, ct_reg, trim_reg, pend_reg;
	logic                user_trim_enable_reg, upd_reg, cal_src_reg;
	logic [1:0]          apply_cnt_reg;
	logic [1:0]          res_reg;
	logic [CNT_W-1:0]    osc_cnt_reg;
	logic [4:0]          ref_cnt_reg;
	logic [11:0]         tmo_reg;
	logic [31:0]         rdata_reg;

	// Bus decode
	wire wr_ctrl  = wr_i && addr_i == OSCC_CTRL_OFS;
	wire start    = wr_ctrl && wdata_i[OSCC_CAL_BIT];              // RULE_03
	wire upd_req  = wr_ctrl && wdata_i[OSCC_UPD_BIT];
	wire busy     = state_reg != OSCC_IDLE;

	// Reference synchroniser: third and second stages must agree
	wire ref_lvl  = ref_sync_reg[2];
	wire ref_rise = ref_sync_reg[1] && ref_sync_reg[2] && !ref_prev_reg;
	wire tmo_hit  = tmo_reg == 12'(OSCC_REF_TMO - 1);
	wire meas_end = ref_rise && ref_cnt_reg == 5'(OSCC_REF_PERIODS - 1);

	// Trim step from measured count: fast osc (count high) -> raise trim
	function automatic logic [TRIM_W-1:0] oscc_adjust(
		input logic [TRIM_W-1:0] cur,
		input logic [CNT_W-1:0]  cnt
	);
		logic signed [CNT_W+1:0] err;
		logic signed [TRIM_W+1:0] nxt;
		err = $signed({2'b00, cnt}) - (CNT_W+2)'(OSCC_TARGET);
		// Divide toward zero: one-count phase jitter leaves trim alone
		nxt = $signed({2'b00, cur}) + (TRIM_W+2)'(err / 16);    // RULE_07
		if (nxt < 0)
			oscc_adjust = '0;
		else if (nxt > (TRIM_W+2)'((1 << TRIM_W) - 1))
			oscc_adjust = '1;
		else
			oscc_adjust = nxt[TRIM_W-1:0];
	endfunction : oscc_adjust

	// Calibration state machine
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			OSCC_IDLE: if (start) state_next = OSCC_SYNC;            // RULE_03
			OSCC_SYNC: begin
				if (tmo_hit) state_next = OSCC_DONE;
				else if (ref_rise) state_next = OSCC_MEAS;           // RULE_02
			end
			OSCC_MEAS: if (meas_end || tmo_hit) state_next = OSCC_DONE;
			OSCC_DONE: state_next = OSCC_IDLE;
			default:   state_next = OSCC_IDLE;
		endcase
	end

	// State and reference sampling
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			state_reg    <= OSCC_IDLE;
			ref_sync_reg <= 3'h0;
			ref_prev_reg <= 1'b0;
		end else begin
			state_reg    <= state_next;
			ref_sync_reg <= {ref_sync_reg[1:0], ref_clk_i};
			if (ref_sync_reg[1] == ref_sync_reg[2])
				ref_prev_reg <= ref_lvl;
		end
	end

	// Oscillator cycles per reference window, timeout watchdog
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			osc_cnt_reg <= '0;
			ref_cnt_reg <= 5'h0;
			tmo_reg     <= 12'h0;
		end else begin
			if (state_reg == OSCC_IDLE || ref_rise)
				tmo_reg <= 12'h0;
			else
				tmo_reg <= tmo_reg + 12'h1;
			if (state_reg != OSCC_MEAS) begin
				osc_cnt_reg <= '0;
				ref_cnt_reg <= 5'h0;
			end else begin
				osc_cnt_reg <= osc_cnt_reg + CNT_W'(1);              // RULE_02
				if (ref_rise)
					ref_cnt_reg <= ref_cnt_reg + 5'h1;
			end
		end
	end

	// Result and computed trim
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			res_reg <= OSCC_RES_NONE;
			ct_reg  <= OSCC_TRIM_RST;
		end else if (state_reg == OSCC_MEAS && meas_end) begin
			res_reg <= OSCC_RES_OK;                                  // RULE_04
			ct_reg  <= oscc_adjust(trim_reg, osc_cnt_reg);           // RULE_01
		end else if (busy && tmo_hit) begin
			res_reg <= OSCC_RES_FAIL;                                // RULE_04
		end else if (start) begin
			res_reg <= OSCC_RES_NONE;
		end
	end

	// User trim fields; trim written only while enabled or by the write that sets enable
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			user_trim_enable_reg <= 1'b0;
			ut_reg   <= OSCC_TRIM_RST;
		end else if (wr_ctrl) begin
			user_trim_enable_reg <= wdata_i[OSCC_USER_TRIM_ENABLE_BIT];
			if (user_trim_enable_reg || wdata_i[OSCC_USER_TRIM_ENABLE_BIT])
				ut_reg <= wdata_i[OSCC_UT_LSB +: TRIM_W];            // RULE_06
		end
	end

	// Staged apply: hold pending value, swap after settle delay
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			upd_reg       <= 1'b0;
			cal_src_reg   <= 1'b0;
			pend_reg      <= OSCC_TRIM_RST;
			apply_cnt_reg <= 2'h0;
			trim_reg      <= OSCC_TRIM_RST;
		end else if (state_reg == OSCC_MEAS && meas_end) begin
			upd_reg       <= 1'b1;
			cal_src_reg   <= 1'b1;
			pend_reg      <= oscc_adjust(trim_reg, osc_cnt_reg);     // RULE_05
			apply_cnt_reg <= 2'h0;
		end else if (upd_req && user_trim_enable_reg && !upd_reg) begin
			upd_reg       <= 1'b1;                                   // RULE_08
			cal_src_reg   <= 1'b0;
			pend_reg      <= wdata_i[OSCC_UT_LSB +: TRIM_W];
			apply_cnt_reg <= 2'h0;
		end else if (upd_reg) begin
			if (apply_cnt_reg == 2'(OSCC_APPLY_CYC - 1)) begin
				trim_reg <= pend_reg;   // One-edge swap: glitch free // RULE_09
				upd_reg  <= 1'b0;                                    // RULE_10
			end else begin
				apply_cnt_reg <= apply_cnt_reg + 2'h1;
			end
		end
	end

	// Read mux
	always_comb begin
		rdata_reg = 32'h0;
		case (addr_i)
			OSCC_CTRL_OFS: begin
				rdata_reg[OSCC_UT_LSB +: TRIM_W] = ut_reg;
				rdata_reg[OSCC_UPD_BIT]  = upd_reg;                  // RULE_10
				rdata_reg[OSCC_CAL_BIT]  = busy;
				rdata_reg[OSCC_USER_TRIM_ENABLE_BIT] = user_trim_enable_reg;
			end
			OSCC_STAT_OFS: begin
				rdata_reg[OSCC_CT_LSB +: TRIM_W] = ct_reg;           // RULE_05
				rdata_reg[OSCC_RES_LSB +: 2]     = res_reg;          // RULE_04
				rdata_reg[OSCC_BUSY_BIT]         = busy;
			end
			OSCC_CFG_OFS: rdata_reg = 32'(trim_reg);
			default: rdata_reg = 32'h0;
		endcase
	end

	// Registered outputs
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			rdata_o <= 32'h0;
			trim_o  <= OSCC_TRIM_RST;
		end else begin
			if (rd_i)
				rdata_o <= rdata_reg;
			trim_o <= trim_reg;                                      // RULE_07
		end
	end
endmodule : oscc_trim

// ==== tb/oscc_trim_assertions.sv ====
// Port checker for the oscillator trim controller
`timescale 1ns/10ps
module oscc_trim_assertions
	import oscc_pkg::*;
#(
	parameter int TRIM_W = OSCC_TRIM_W // Trim code width
) (
	input wire logic              sys_clk_i, // Clock
	input wire logic              rst_n_i,   // Sync reset, active low
	input wire logic              ref_clk_i, // Reference level
	input wire logic [3:0]        addr_i,    // Byte address
	input wire logic [31:0]       wdata_i,   // Write data
	input wire logic              wr_i,      // Write strobe
	input wire logic              rd_i,      // Read strobe
	input wire logic [31:0]       rdata_o,   // Read data
	input wire logic [TRIM_W-1:0] trim_o     // Applied trim
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Decoded accesses
	wire ctl_w = wr_i && addr_i == OSCC_CTRL_OFS;
	wire upd_w = ctl_w && wdata_i[OSCC_USER_TRIM_ENABLE_BIT] && wdata_i[OSCC_UPD_BIT];
	wire cal_w = ctl_w && wdata_i[OSCC_CAL_BIT];
	wire rdc_w = rd_i && addr_i == OSCC_CTRL_OFS;
	wire rds_w = rd_i && addr_i == OSCC_STAT_OFS;
	wire [TRIM_W-1:0] ut_w = wdata_i[TRIM_W-1:0];
	wire [TRIM_W-1:0] ct_w = rdata_o[TRIM_W-1:0];
	property p_rst; $rose(rst_n_i) |-> trim_o == OSCC_TRIM_RST; endproperty
	property p_hold; !$past(rd_i) |-> $stable(rdata_o); endproperty
	property p_gap; upd_w |=> $stable(trim_o) [*4]; endproperty
	property p_apply; upd_w |-> ##5 trim_o == $past(ut_w, 5); endproperty
	property p_pend; upd_w ##2 rdc_w |=> rdata_o[OSCC_UPD_BIT]; endproperty
	property p_busy; cal_w ##2 rdc_w |=> rdata_o[OSCC_CAL_BIT]; endproperty
	property p_meas; cal_w |=> $stable(trim_o) [*8]; endproperty
	property p_ct;
		rds_w ##1 (rdata_o[9:8] == OSCC_RES_OK && !rdata_o[OSCC_BUSY_BIT])
		|-> ##4 trim_o == $past(ct_w, 4);
	endproperty
	property p_rb;
		rd_i && addr_i == OSCC_CFG_OFS |=> ct_w == $past(trim_o);
	endproperty
	a_rst: assert property (p_rst)
		else $error("trim not mid scale after reset");
	a_hold: assert property (p_hold)
		else $error("read data moved without a read");
	a_gap: assert property (p_gap)
		else $error("trim moved early after update");
	a_apply: assert property (p_apply)
		else $error("user trim not applied in time");
	a_pend: assert property (p_pend)
		else $error("update bit not pending");
	a_busy: assert property (p_busy)
		else $error("calibration not running");
	a_meas: assert property (p_meas)
		else $error("trim moved before measuring");
	a_ct: assert property (p_ct)
		else $error("computed trim not applied");
	a_rb: assert property (p_rb)
		else $error("trim readback wrong");
	c_upd: cover property (upd_w);
	c_cal: cover property (cal_w);
	c_fail: cover property (rds_w ##1 rdata_o[9:8] == OSCC_RES_FAIL);
endmodule : oscc_trim_assertions
bind oscc_trim oscc_trim_assertions #(.TRIM_W(TRIM_W)) i_chk (.sys_clk_i,
	.rst_n_i, .ref_clk_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .trim_o);

// ==== tb/oscc_ref_model.sv ====
// Low frequency reference clock source
`timescale 1ns/10ps
module oscc_ref_model #(
	parameter real HALF = 1220.0 // Half period, 488 clocks per period
) (
	input  wire logic run_i, // Reference running
	output logic      ref_o  // Reference level
);
	// Toggles while running, parks low when stopped
	initial begin
		ref_o = 1'b0;
		forever begin
			#HALF;
			ref_o = run_i ? ~ref_o : 1'b0;
		end
	end
endmodule : oscc_ref_model

// ==== tb/tb_top.sv ====
// Testbench for the oscillator trim controller
`timescale 1ns/10ps
module tb_top;
	import oscc_pkg::*;
	logic        sys_clk_i = 1'b0;
	logic        rst_n_i   = 1'b0;
	logic        run       = 1'b1;
	logic        ref_clk;
	logic [3:0]  addr_i    = '0;
	logic [31:0] wdata_i   = '0;
	logic        wr_i      = 1'b0;
	logic        rd_i      = 1'b0;
	logic        rd_q      = 1'b0;
	logic [31:0] rdata_o;
	logic [6:0]  trim_o;
	logic [6:0]  ut;
	logic [31:0] seed      = 32'h03ea;
	logic [31:0] last_rd   = '0;
	logic [63:0] ent;
	logic [63:0] exp_q[$];
	int          errors      = 0;
	int          check_count = 0;
	always #2.5 sys_clk_i = ~sys_clk_i;
	oscc_ref_model i_oscc_ref_model (.run_i(run), .ref_o(ref_clk));
	oscc_trim i_oscc_trim (.sys_clk_i, .rst_n_i, .ref_clk_i(ref_clk),
		.addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .trim_o);
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	task automatic check(input string n, input logic [31:0] s, e);
		check_count++;
		if (s !== e) begin
			errors++;
			$display("mismatch %s exp %h seen %h", n, e, s);
		end
	endtask : check
	task automatic test_done();
		if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : test_done
	task automatic cyc(input logic w, r, input logic [3:0] a, input [31:0] d);
		wr_i <= w;
		rd_i <= r;
		addr_i <= a;
		wdata_i <= d;
		@(posedge sys_clk_i);
	endtask : cyc
	task automatic rd(input logic [3:0] a, input logic [31:0] e, m);
		exp_q.push_back({m, e});
		cyc(1'b0, 1'b1, a, '0);
	endtask : rd
	task automatic poll();
		last_rd = '1;
		for (int n = 0; n < 5000 && last_rd[OSCC_BUSY_BIT]; n++) begin
			rd(OSCC_STAT_OFS, '0, '0);
			repeat (2) cyc(1'b0, 1'b0, 4'h0, '0);
		end
	endtask : poll
	// Read data monitor, compares against the oldest note
	always @(posedge sys_clk_i) begin
		rd_q <= rd_i;
		if (rd_q) begin
			ent = exp_q.pop_front();
			last_rd = rdata_o;
			if (ent[63:32] != '0)
				check("rdata", rdata_o & ent[63:32],
					ent[31:0] & ent[63:32]);
		end
	end
	// Main sequence
	initial begin
		repeat (10) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		check("trim", {25'h0, trim_o}, {25'h0, OSCC_TRIM_RST});
		rd(4'hc, '0, '1);
		cyc(1'b1, 1'b0, OSCC_CTRL_OFS, 32'h17f);
		repeat (6) cyc(1'b0, 1'b0, 4'h0, '0);
		check("trim", {25'h0, trim_o}, {25'h0, OSCC_TRIM_RST});
		for (int i = 0; i < 3; i++) begin
			seed = xs(seed);
			ut = (i == 0) ? 7'h00 : (i == 1) ? 7'h7f : seed[6:0];
			cyc(1'b1, 1'b0, OSCC_CTRL_OFS, 32'h8000_0000);
			cyc(1'b1, 1'b0, OSCC_CTRL_OFS, {1'b1, 24'h0, ut});
			cyc(1'b1, 1'b0, OSCC_CTRL_OFS, {1'b1, 22'h0, 2'h2, ut});
			cyc(1'b0, 1'b0, 4'h0, '0);
			rd(OSCC_CTRL_OFS, 32'h100, 32'h100);
			repeat (4) cyc(1'b0, 1'b0, 4'h0, '0);
			check("trim", {25'h0, trim_o}, {25'h0, ut});
			rd(OSCC_CTRL_OFS, 32'h0, 32'h100);
			rd(OSCC_CFG_OFS, {25'h0, ut}, 32'h7f);
		end
		cyc(1'b1, 1'b0, OSCC_CTRL_OFS, 32'h200);
		cyc(1'b0, 1'b0, 4'h0, '0);
		rd(OSCC_CTRL_OFS, 32'h200, 32'h200);
		poll();
		check("stat", {22'h0, last_rd[9:0]}, {22'h0, OSCC_RES_OK, 1'b0, ut});
		repeat (4) cyc(1'b0, 1'b0, 4'h0, '0);
		check("trim", {25'h0, trim_o}, {25'h0, ut});
		run <= 1'b0;
		cyc(1'b1, 1'b0, OSCC_CTRL_OFS, 32'h200);
		poll();
		check("fail", {30'h0, last_rd[9:8]}, {30'h0, OSCC_RES_FAIL});
		check("trim", {25'h0, trim_o}, {25'h0, ut});
		test_done();
	end
	// Watchdog against a hang
	initial begin
		#200us;
		errors++;
		test_done();
	end
endmodule : tb_top
